// [logic/fwp_consts.svh]
`ifndef FWP_CONSTS_SVH
`define FWP_CONSTS_SVH

// Register map of the controller's own command port
`define FWP_REG_CTRL 4'h0
`define FWP_REG_ADDR 4'h1
`define FWP_REG_DATA 4'h2
`define FWP_REG_STAT 4'h3
`define FWP_REG_RDAT 4'h4
`define FWP_REG_UNIT 4'h5

// Control register bits (write)
`define FWP_CTRL_GO_BIT 0
`define FWP_CTRL_CMD_LSB 1
`define FWP_CTRL_CMD_MSB 3
`define FWP_CTRL_WP_BIT 4
`define FWP_CTRL_HV_BIT 5
`define FWP_CTRL_RST_BIT 6

// Command codes carried in the control register
`define FWP_CMD_READ 3'h0
`define FWP_CMD_WRITE 3'h1
`define FWP_CMD_SECURE_ENTER 3'h2
`define FWP_CMD_SECURE_EXIT 3'h3

// Bus cycle timing: strobe phase length, a plain default to be set for the fitted part
`define FWP_T_CYCLE_NS 80
`define FWP_CLK_NS 8
`define FWP_CYC_COUNT ((`FWP_T_CYCLE_NS + `FWP_CLK_NS - 1) / `FWP_CLK_NS)
`define FWP_T_GLITCH_NS 5
`define FWP_WE_MIN_COUNT (((`FWP_T_GLITCH_NS + `FWP_CLK_NS - 1) / `FWP_CLK_NS) + 1)

// Unlock addresses and data for the secured-region enter and exit sequences
`define FWP_UNLOCK_A1 20'h00555
`define FWP_UNLOCK_A2 20'h002AA
`define FWP_UNLOCK_D1 16'h00AA
`define FWP_UNLOCK_D2 16'h0055
`define FWP_ENTER_D3 16'h0088
`define FWP_EXIT_D3 16'h0090
`define FWP_EXIT_D4 16'h0000

// Number of protection units and reset values
`define FWP_UNITS 17
`define FWP_ADDR_W 20
`define FWP_DATA_W 16
`define FWP_ZERO16 16'h0000
`define FWP_ZERO20 20'h00000

`endif

// [logic/fwp_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fwp_consts.svh"

// Functional notes
// - Protect changes use bus cycles, reset elevated
// - Protect all units before first unprotect
// - Host always drives write-protect pin
// - Lock region: enter sequence then protect
// - Write needs chip, write enable low, OE high
module fwp_host (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic [19:0] FL_ADDR,
    output logic [15:0] FL_DQ_OUT,
    output logic FL_DQ_OE,
    input wire logic [15:0] FL_DQ_IN,
    output logic FL_CE_N,
    output logic FL_OE_N,
    output logic FL_WE_N,
    output logic FL_RESET_N,
    output logic FL_RESET_HV,
    output logic FL_WRITE_PROTECT_ACCEL_PIN_N,
    output logic [16:0] FL_UNIT_TOUCHED
);
    import fwp_pkg::*;

    // ==========================================================
    // Command registers
    fwp_state_e state;
    fwp_addr_t cmd_addr;
    fwp_data_t cmd_data;
    fwp_cmd_t cmd;
    fwp_data_t rd_data;
    fwp_unit_t last_unit;
    fwp_unit_t dec_unit;
    logic [3:0] cnt;
    logic [1:0] seq_idx;
    logic is_write;
    logic busy;
    logic secure_mode;
    logic seq_active;
    logic [16:0] touched;

    wire logic go = REG_WR && (REG_ADDR == `FWP_REG_CTRL) && REG_WDATA[`FWP_CTRL_GO_BIT] && !busy;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            cmd_addr <= `FWP_ZERO20;
            cmd_data <= `FWP_ZERO16;
        end else if (REG_WR && REG_ADDR == `FWP_REG_ADDR) begin
            cmd_addr <= REG_WDATA[`FWP_ADDR_W-1:0];
        end else if (REG_WR && REG_ADDR == `FWP_REG_DATA) begin
            cmd_data <= REG_WDATA[`FWP_DATA_W-1:0];
        end
    end

    // Pin levels: always driven to a defined level from reset
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            FL_WRITE_PROTECT_ACCEL_PIN_N <= 1'b1;
            FL_RESET_HV <= 1'b0;
            FL_RESET_N <= 1'b0;
        end else if (REG_WR && REG_ADDR == `FWP_REG_CTRL && !busy) begin
            FL_WRITE_PROTECT_ACCEL_PIN_N <= REG_WDATA[`FWP_CTRL_WP_BIT];
            FL_RESET_HV <= REG_WDATA[`FWP_CTRL_HV_BIT];
            FL_RESET_N <= REG_WDATA[`FWP_CTRL_RST_BIT];
        end
    end

    // ==========================================================
    // Sequence selection: one bus cycle or a secured-region command
    function automatic fwp_addr_t seq_addr(input fwp_cmd_t c, input logic [1:0] i, input fwp_addr_t a);
        fwp_addr_t r;
        r = a;
        if (c == `FWP_CMD_SECURE_ENTER || c == `FWP_CMD_SECURE_EXIT) begin
            case (i)
                2'h0: r = `FWP_UNLOCK_A1;
                2'h1: r = `FWP_UNLOCK_A2;
                2'h2: r = `FWP_UNLOCK_A1;
                default: r = `FWP_ZERO20;
            endcase
        end
        return r;
    endfunction

    function automatic fwp_data_t seq_data(input fwp_cmd_t c, input logic [1:0] i, input fwp_data_t d);
        fwp_data_t r;
        r = d;
        if (c == `FWP_CMD_SECURE_ENTER || c == `FWP_CMD_SECURE_EXIT) begin
            case (i)
                2'h0: r = `FWP_UNLOCK_D1;
                2'h1: r = `FWP_UNLOCK_D2;
                2'h2: r = (c == `FWP_CMD_SECURE_ENTER) ? `FWP_ENTER_D3 : `FWP_EXIT_D3;
                default: r = `FWP_EXIT_D4;
            endcase
        end
        return r;
    endfunction

    function automatic logic [1:0] seq_last(input fwp_cmd_t c);
        logic [1:0] r;
        r = 2'h0;
        if (c == `FWP_CMD_SECURE_ENTER) begin
            r = 2'h2;
        end else if (c == `FWP_CMD_SECURE_EXIT) begin
            r = 2'h3;
        end
        return r;
    endfunction

    // ==========================================================
    // Bus cycle engine
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state <= FWP_IDLE;
            cmd <= `FWP_CMD_READ;
            cnt <= 4'h0;
            seq_idx <= 2'h0;
            busy <= 1'b0;
            is_write <= 1'b0;
            FL_CE_N <= 1'b1;
            FL_OE_N <= 1'b1;
            FL_WE_N <= 1'b1;
            FL_DQ_OE <= 1'b0;
            FL_ADDR <= `FWP_ZERO20;
            FL_DQ_OUT <= `FWP_ZERO16;
            rd_data <= `FWP_ZERO16;
        end else begin
            case (state)
                FWP_IDLE: begin
                    if (go) begin
                        cmd <= REG_WDATA[`FWP_CTRL_CMD_MSB:`FWP_CTRL_CMD_LSB];
                        is_write <= REG_WDATA[`FWP_CTRL_CMD_MSB:`FWP_CTRL_CMD_LSB] != `FWP_CMD_READ;
                        seq_idx <= 2'h0;
                        busy <= 1'b1;
                        state <= FWP_SETUP;
                    end
                end
                FWP_SETUP: begin
                    FL_ADDR <= seq_addr(cmd, seq_idx, cmd_addr);
                    FL_DQ_OUT <= seq_data(cmd, seq_idx, cmd_data);
                    FL_DQ_OE <= is_write;
                    FL_CE_N <= 1'b0;
                    // OE stays high during writes, so a write never meets OE low
                    FL_OE_N <= is_write;
                    cnt <= 4'h0;
                    state <= FWP_STROBE;
                end
                FWP_STROBE: begin
                    // Write strobe is held well past the glitch filter width
                    FL_WE_N <= !is_write;
                    cnt <= cnt + 4'h1;
                    if (cnt == 4'(`FWP_CYC_COUNT - 1)) begin
                        state <= FWP_HOLD;
                    end
                end
                FWP_HOLD: begin
                    if (!is_write) begin
                        rd_data <= FL_DQ_IN;
                    end
                    // Write strobe rises alone; CE and OE follow a cycle later so the write latches cleanly
                    FL_WE_N <= 1'b1;
                    state <= FWP_SEQ_NEXT;
                end
                FWP_SEQ_NEXT: begin
                    FL_OE_N <= 1'b1;
                    FL_CE_N <= 1'b1;
                    FL_DQ_OE <= 1'b0;
                    if (seq_idx == seq_last(cmd)) begin
                        state <= FWP_DONE;
                    end else begin
                        seq_idx <= seq_idx + 2'h1;
                        state <= FWP_SETUP;
                    end
                end
                FWP_DONE: begin
                    busy <= 1'b0;
                    state <= FWP_IDLE;
                end
                default: begin
                    state <= FWP_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Secured-region mapping as tracked by the host
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            secure_mode <= 1'b0;
        end else if (!FL_RESET_N) begin
            secure_mode <= 1'b0;
        end else if (state == FWP_DONE && cmd == `FWP_CMD_SECURE_ENTER) begin
            secure_mode <= 1'b1;
        end else if (state == FWP_DONE && cmd == `FWP_CMD_SECURE_EXIT) begin
            secure_mode <= 1'b0;
        end
    end

    assign seq_active = busy;

    fwp_unit_decode u_dec (
        .SYS_CLK(SYS_CLK),
        .RST_N(RST_N),
        .addr(cmd_addr),
        .unit(dec_unit)
    );

    // Units written with the reset pin elevated, for software to check the protect-all step
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            touched <= 17'h00000;
        end else begin
            // A clear in the same cycle as a recorded write keeps the new unit
            if (REG_WR && REG_ADDR == `FWP_REG_UNIT) begin
                touched <= 17'h00000;
            end
            if (state == FWP_DONE && is_write && FL_RESET_HV) begin
                touched[dec_unit] <= 1'b1;
            end
        end
    end

    // Unit of the last completed write, for the status register
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            last_unit <= 5'h00;
        end else if (state == FWP_DONE && is_write) begin
            last_unit <= dec_unit;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            FL_UNIT_TOUCHED <= 17'h00000;
        end else begin
            FL_UNIT_TOUCHED <= touched;
        end
    end

    // ==========================================================
    // Register read port, data one cycle after the strobe
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            REG_RDATA <= 32'h00000000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `FWP_REG_ADDR: REG_RDATA <= {12'h000, cmd_addr};
                `FWP_REG_DATA: REG_RDATA <= {16'h0000, cmd_data};
                `FWP_REG_STAT: REG_RDATA <= {24'h000000, last_unit, secure_mode, FL_RESET_HV, seq_active};
                `FWP_REG_RDAT: REG_RDATA <= {16'h0000, rd_data};
                `FWP_REG_UNIT: REG_RDATA <= {15'h0000, touched};
                default: REG_RDATA <= 32'h00000000;
            endcase
        end else begin
            REG_RDATA <= 32'h00000000;
        end
    end

    // ==========================================================
    // Checks
    write_oe_high_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !FL_WE_N |-> (FL_OE_N && !FL_CE_N)) else $error("write strobe with OE low or CE high");
    we_width_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $fell(FL_WE_N) |-> !FL_WE_N [*2]) else $error("write strobe too short");
    secure_reset_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !FL_RESET_N |=> !secure_mode) else $error("secured mapping survived reset");
    busy_done_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        go |=> busy ##[1:80] !busy) else $error("cycle did not finish");
    wp_steady_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        busy && $past(busy) |-> $stable(FL_WRITE_PROTECT_ACCEL_PIN_N)) else $error("WP changed mid cycle");
    dq_write_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !FL_WE_N |-> FL_DQ_OE) else $error("data bus not driven during write");
    enter_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        state == FWP_DONE && cmd == `FWP_CMD_SECURE_ENTER && FL_RESET_N |=> secure_mode)
        else $error("enter sequence not tracked");
    hv_touch_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        state == FWP_DONE && is_write && FL_RESET_HV
        |=> touched[$past(dec_unit)]) else $error("protect write not recorded");
    cov_write_c: cover property (@(posedge SYS_CLK) state == FWP_DONE && cmd == `FWP_CMD_WRITE);
    cov_enter_c: cover property (@(posedge SYS_CLK) $rose(secure_mode));
    cov_hv_c: cover property (@(posedge SYS_CLK) FL_RESET_HV && !FL_WE_N);
endmodule

`default_nettype wire

// [logic/fwp_pkg.sv]
package fwp_pkg;
    typedef enum {
        FWP_IDLE,
        FWP_SETUP,
        FWP_STROBE,
        FWP_HOLD,
        FWP_SEQ_NEXT,
        FWP_DONE
    } fwp_state_e;
    typedef logic [19:0] fwp_addr_t;
    typedef logic [15:0] fwp_data_t;
    typedef logic [2:0] fwp_cmd_t;
    typedef logic [4:0] fwp_unit_t;
endpackage

// [logic/fwp_unit_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fwp_consts.svh"

// Maps a word address onto its protection unit index
module fwp_unit_decode (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire fwp_pkg::fwp_addr_t addr,
    output fwp_pkg::fwp_unit_t unit
);
    import fwp_pkg::*;

    function automatic fwp_unit_t unit_of(input logic [7:0] sa);
        fwp_unit_t u;
        u = 5'h00;
        if (sa[7:3] == 5'h00) begin
            u = fwp_unit_t'(sa[2:0]);
        end else if (sa[7:5] == 3'h0) begin
            u = 5'h08;
        end else if (sa[7:3] == 5'h1F) begin
            u = 5'h10;
        end else if (sa[7:5] == 3'h7) begin
            u = 5'h0F;
        end else begin
            u = fwp_unit_t'({2'h0, sa[7:5]} + 5'h08);
        end
        return u;
    endfunction

    // Sector address is word address bits 19..12
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            unit <= 5'h00;
        end else begin
            unit <= unit_of(addr[19:12]);
        end
    end
endmodule

`default_nettype wire

// [verif/flash_sector_write_protection_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fwp_consts.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
    $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module flash_sector_write_protection_tb;
    logic SYS_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [3:0] REG_ADDR = 4'h0;
    logic [31:0] REG_WDATA = 32'h00000000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [31:0] REG_RDATA;
    logic [19:0] FL_ADDR;
    logic [15:0] FL_DQ_OUT;
    logic [15:0] FL_DQ_IN;
    logic FL_DQ_OE, FL_CE_N, FL_OE_N, FL_WE_N, FL_RESET_N, FL_RESET_HV, FL_WRITE_PROTECT_ACCEL_PIN_N;
    logic [16:0] FL_UNIT_TOUCHED;
    int err_total = 0;
    int num_checks = 0;
    logic wp = 1'b1;
    logic hv = 1'b0;
    logic rstn = 1'b1;
    logic [31:0] r;

    always #4 SYS_CLK = ~SYS_CLK;

    fwp_host u_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FL_ADDR(FL_ADDR), .FL_DQ_OUT(FL_DQ_OUT),
        .FL_DQ_OE(FL_DQ_OE), .FL_DQ_IN(FL_DQ_IN), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
        .FL_RESET_N(FL_RESET_N), .FL_RESET_HV(FL_RESET_HV), .FL_WRITE_PROTECT_ACCEL_PIN_N(FL_WRITE_PROTECT_ACCEL_PIN_N),
        .FL_UNIT_TOUCHED(FL_UNIT_TOUCHED));
    fwp_flash_model u_mem (.addr(FL_ADDR), .dq_out(FL_DQ_OUT), .dq_oe(FL_DQ_OE), .dq_in(FL_DQ_IN),
        .ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N), .reset_n(FL_RESET_N), .reset_hv(FL_RESET_HV),
        .wp_n(FL_WRITE_PROTECT_ACCEL_PIN_N));

    // ==========================================
    // Register port and flash operation helpers
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
    endtask
    function automatic logic [31:0] ctl(input logic [2:0] cmd, input logic go);
        return {25'h0000000, rstn, hv, wp, cmd, go};
    endfunction
    task automatic pins();
        reg_wr(`FWP_REG_CTRL, ctl(`FWP_CMD_READ, 1'b0));
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        r = 32'h00000001;
        while (r[0] !== 1'b0 && n < 40) begin
            reg_rd(`FWP_REG_STAT, r);
            n++;
        end
        `CHK("busy", 1'b0, r[0])
    endtask
    task automatic op(input logic [2:0] cmd, input logic [19:0] a, input logic [15:0] d);
        reg_wr(`FWP_REG_ADDR, {12'h000, a});
        reg_wr(`FWP_REG_DATA, {16'h0000, d});
        reg_wr(`FWP_REG_CTRL, ctl(cmd, 1'b1));
        wait_idle();
    endtask
    task automatic rd_chk(input logic [19:0] a, input logic [15:0] ex);
        op(`FWP_CMD_READ, a, 16'h0000);
        reg_rd(`FWP_REG_RDAT, r);
        `CHK("flash word", ex, r[15:0])
    endtask
    function automatic logic [19:0] base(input int u);
        if (u < 8) return 20'(u * 'h1000);
        if (u == 8) return 20'h08000;
        if (u < 15) return 20'((u - 8) * 'h20000);
        return (u == 15) ? 20'hE0000 : 20'hF8000;
    endfunction

    // ==========================================
    // Scenarios
    task automatic t_reset();
        `CHK("ce_n", 1'b1, FL_CE_N)
        `CHK("we_n", 1'b1, FL_WE_N)
        `CHK("oe_n", 1'b1, FL_OE_N)
        `CHK("dq_oe", 1'b0, FL_DQ_OE)
        `CHK("flash addr", 20'h00000, FL_ADDR)
        `CHK("wp pin", 1'b1, FL_WRITE_PROTECT_ACCEL_PIN_N)
        `CHK("hv", 1'b0, FL_RESET_HV)
        `CHK("reset pin", 1'b0, FL_RESET_N)
        reg_rd(4'h6, r);
        `CHK("unmapped", 32'h00000000, r)
        pins();
        #1 `CHK("reset pin", 1'b1, FL_RESET_N)
        $display("t_reset done");
    endtask
    task automatic t_write();
        op(`FWP_CMD_WRITE, 20'h08004, 16'h1234);
        rd_chk(20'h08004, 16'h1234);
        reg_rd(`FWP_REG_STAT, r);
        `CHK("last unit", 5'h08, r[7:3])
        `CHK("bad cycles", 0, u_mem.bad_cycles)
        $display("t_write done");
    endtask
    task automatic t_wp();
        wp = 1'b0;
        pins();
        op(`FWP_CMD_WRITE, 20'h01010, 16'h5A5A);
        `CHK("wp pin", 1'b0, FL_WRITE_PROTECT_ACCEL_PIN_N)
        rd_chk(20'h01010, 16'hFFFF);
        op(`FWP_CMD_WRITE, 20'h02000, 16'hA5A5);
        rd_chk(20'h02000, 16'hA5A5);
        wp = 1'b1;
        pins();
        op(`FWP_CMD_WRITE, 20'h01010, 16'h5A5A);
        rd_chk(20'h01010, 16'h5A5A);
        $display("t_wp done");
    endtask
    task automatic t_prot();
        hv = 1'b1;
        pins();
        #1 `CHK("hv", 1'b1, FL_RESET_HV)
        reg_wr(`FWP_REG_UNIT, 32'h00000000);
        for (int u = 0; u < 17; u++) op(`FWP_CMD_WRITE, base(u), 16'h0060);
        reg_rd(`FWP_REG_UNIT, r);
        `CHK("unit map", 17'h1FFFF, r[16:0])
        `CHK("touched pins", 17'h1FFFF, FL_UNIT_TOUCHED)
        hv = 1'b0;
        pins();
        op(`FWP_CMD_WRITE, 20'h20000, 16'h1111);
        rd_chk(20'h20000, 16'hFFFF);
        hv = 1'b1;
        pins();
        reg_rd(`FWP_REG_STAT, r);
        `CHK("hv status", 1'b1, r[1])
        op(`FWP_CMD_WRITE, 20'h20000, 16'h2222);
        rd_chk(20'h20000, 16'h2222);
        hv = 1'b0;
        pins();
        op(`FWP_CMD_WRITE, 20'h20000, 16'h3333);
        rd_chk(20'h20000, 16'h2222);
        hv = 1'b1;
        pins();
        op(`FWP_CMD_WRITE, 20'h20000, 16'h0040);
        hv = 1'b0;
        pins();
        op(`FWP_CMD_WRITE, 20'h40000, 16'h4444);
        rd_chk(20'h40000, 16'h4444);
        reg_wr(`FWP_REG_UNIT, 32'h00000001);
        reg_rd(`FWP_REG_UNIT, r);
        `CHK("unit map", 17'h00000, r[16:0])
        `CHK("touched pins", 17'h00000, FL_UNIT_TOUCHED)
        $display("t_prot done");
    endtask
    task automatic t_sec();
        op(`FWP_CMD_SECURE_ENTER, 20'h00000, 16'h0000);
        reg_rd(`FWP_REG_STAT, r);
        `CHK("secure", 1'b1, r[2])
        `CHK("entered", 1'b1, u_mem.sec_mode)
        rd_chk(20'h00003, 16'hE503);
        op(`FWP_CMD_WRITE, 20'h00003, 16'h0000);
        rd_chk(20'h00003, 16'hE503);
        op(`FWP_CMD_SECURE_EXIT, 20'h00000, 16'h0000);
        reg_rd(`FWP_REG_STAT, r);
        `CHK("secure", 1'b0, r[2])
        rd_chk(20'h01010, 16'h5A5A);
        op(`FWP_CMD_SECURE_ENTER, 20'h00000, 16'h0000);
        rstn = 1'b0;
        pins();
        reg_rd(`FWP_REG_STAT, r);
        `CHK("secure", 1'b0, r[2])
        rstn = 1'b1;
        pins();
        rd_chk(20'h01010, 16'h5A5A);
        $display("t_sec done");
    endtask
    task automatic t_busy();
        reg_wr(`FWP_REG_ADDR, 32'h00060000);
        reg_wr(`FWP_REG_DATA, 32'h00007777);
        reg_wr(`FWP_REG_CTRL, ctl(`FWP_CMD_WRITE, 1'b1));
        wp = 1'b0;
        reg_wr(`FWP_REG_CTRL, ctl(`FWP_CMD_READ, 1'b1));
        wp = 1'b1;
        #1 `CHK("wp pin", 1'b1, FL_WRITE_PROTECT_ACCEL_PIN_N)
        wait_idle();
        rd_chk(20'h60000, 16'h7777);
        $display("t_busy done");
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge SYS_CLK);
        $display("watchdog expired");
        err_total++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        t_reset();
        t_write();
        t_wp();
        t_prot();
        t_sec();
        t_busy();
        end_sim();
    end
endmodule
`default_nettype wire

// [verif/fwp_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Behavioural flash device with sector protection
module fwp_flash_model #(
    parameter bit SEC_FACTORY = 1'b1
) (
    input wire logic [19:0] addr,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    output logic [15:0] dq_in,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_n,
    input wire logic reset_hv,
    input wire logic wp_n
);
    logic [15:0] mem [int];
    logic [16:0] prot = 17'h00000;
    logic sec_mode = 1'b0;
    logic [15:0] last = 16'h0000;
    int ucnt = 0;
    int bad_cycles = 0;
    realtime t_fall = 0;

    function automatic int unit_of(input logic [19:0] a);
        if (a[19:15] == 5'h00) return int'(a[14:12]);
        if (a[19:17] == 3'h0) return 8;
        if (a[19:17] != 3'h7) return 8 + int'(a[19:17]);
        return (a[16:15] == 2'h3) ? 16 : 15;
    endfunction

    function automatic logic blocked(input logic [19:0] a);
        if (sec_mode) return SEC_FACTORY;
        return (!wp_n && unit_of(a) < 2) || (prot[unit_of(a)] && !reset_hv);
    endfunction

    function automatic logic [15:0] rd(input logic [19:0] a);
        if (sec_mode && a[19:15] == 5'h00) return (a < 20'h00008) ? 16'hE500 + a[15:0] : 16'hFFFF;
        return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
    endfunction

    always @(negedge we_n) begin
        t_fall = $realtime;
        if (ce_n === 1'b0 && oe_n === 1'b0) bad_cycles++;
    end
    always @(negedge reset_n) begin
        sec_mode = 1'b0;
        ucnt = 0;
    end
    // Short strobes, reset low and bad control levels never latch a write
    always @(posedge we_n) begin
        if (reset_n === 1'b1 && ce_n === 1'b0 && oe_n === 1'b1 && dq_oe === 1'b1 && $realtime - t_fall >= 5.0) begin
            if (addr == 20'h00555 && dq_out == 16'h00AA) ucnt = 1;
            else if (ucnt == 1 && dq_out == 16'h0055) ucnt = 2;
            else if (ucnt == 2 && dq_out == 16'h0088) sec_mode = 1'b1;
            else if (ucnt == 2 && dq_out == 16'h0090) ucnt = 3;
            else if (ucnt == 3) sec_mode = 1'b0;
            else if (reset_hv && dq_out == 16'h0060) prot[unit_of(addr)] = 1'b1;
            else if (reset_hv && dq_out == 16'h0040) prot = 17'h00000;
            else if (!blocked(addr)) mem[int'(addr)] = dq_out;
        end
    end

    // Released bus shows the inverse of the last driven word
    always @* begin
        if (ce_n === 1'b0 && oe_n === 1'b0 && we_n === 1'b1) begin
            dq_in = rd(addr);
            last = dq_in;
        end else begin
            dq_in = ~last;
        end
    end
endmodule
`default_nettype wire
